// ===== hdl/timer_ctl.sv
// Control, interrupt mask and status of the dual general timer
`include "timer_ctl_defines.svh"

module timer_ctl
    import timer_ctl_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic [11:0] addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [31:0] rdata,
    input  wire logic        cpu_halted,
    input  wire logic [10:0] event_in,
    input  wire logic        first_pwm_raw,
    input  wire logic        second_pwm_raw,
    input  wire logic        first_trig_raw,
    input  wire logic        second_trig_raw,
    input  wire logic        first_cap_in,
    input  wire logic        second_cap_in,
    output logic             first_run,
    output logic             second_run,
    output logic             rtc_run,
    output logic             first_trigger,
    output logic             second_trigger,
    output logic             first_pwm_out,
    output logic             second_pwm_out,
    output logic             first_capture_event,
    output logic             second_capture_event,
    output logic             irq
);
    typedef struct packed {
        logic [14:0] ctl;
        logic [10:0] mask;
        logic [10:0] raw;
        logic [31:0] rdata;
        logic        rtc_run;
        logic        irq;
    } state_t;

    state_t s_q;
    state_t s_d;

    localparam logic [10:0] STATUS_BITS = 11'h70F;

    half_cfg_if first_if ();
    half_cfg_if second_if ();

    logic        first_cap_evt;
    logic        second_cap_evt;
    logic [10:0] events;
    logic [10:0] masked;

    function automatic half_cfg_t half_of(input logic [14:0] c, input int lo);
        half_cfg_t h;
        h.enable   = c[lo];
        h.stall    = c[lo+1];
        h.edge_sel = edge_mode_t'(c[lo+2 +: 2]);
        h.trig_en  = c[lo+5];
        h.invert   = c[lo+6];
        half_of    = h;
    endfunction : half_of

    assign first_if.cfg     = half_of(s_q.ctl, `CTL_FIRST_EN);
    assign first_if.halted  = cpu_halted;
    assign second_if.cfg    = half_of(s_q.ctl, `CTL_SECOND_EN);
    assign second_if.halted = cpu_halted;

    timer_half_gate u_first (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .cfg_in    (first_if),
        .pwm_raw   (first_pwm_raw),
        .trig_raw  (first_trig_raw),
        .cap_in    (first_cap_in),
        .run       (first_run),
        .trig_out  (first_trigger),
        .pwm_out   (first_pwm_out),
        .cap_event (first_cap_evt)
    );

    timer_half_gate u_second (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .cfg_in    (second_if),
        .pwm_raw   (second_pwm_raw),
        .trig_raw  (second_trig_raw),
        .cap_in    (second_cap_in),
        .run       (second_run),
        .trig_out  (second_trigger),
        .pwm_out   (second_pwm_out),
        .cap_event (second_cap_evt)
    );

    assign first_capture_event  = first_cap_evt;
    assign second_capture_event = second_cap_evt;

    // Capture event inputs join external events at the capture-event bits
    always_comb begin
        events     = event_in & STATUS_BITS;
        events[2]  = event_in[2] | first_cap_evt;
        events[10] = event_in[10] | second_cap_evt;
    end

    assign masked = s_q.raw & s_q.mask;

    always_comb begin
        s_d       = s_q;
        s_d.rdata = 32'h0000_0000;
        if (wr_en) begin
            case (addr)
                `OFF_TIMER_CONTROL: begin
                    s_d.ctl = wdata[14:0] & `CTL_WRITE_MASK;
                end
                `OFF_INTERRUPT_MASK: begin
                    s_d.mask = wdata[10:0] & `IM_WRITE_MASK;
                end
                `OFF_INTERRUPT_CLEAR: begin
                    s_d.raw = s_q.raw & ~wdata[10:0];
                end
                default: begin
                end
            endcase
        end
        s_d.raw = s_d.raw | events; // Set wins over a same-cycle clear
        if (rd_en) begin
            case (addr)
                `OFF_TIMER_CONTROL:  s_d.rdata = {17'h0, s_q.ctl};
                `OFF_INTERRUPT_MASK: s_d.rdata = {21'h0, s_q.mask};
                `OFF_RAW_STATUS:     s_d.rdata = {21'h0, s_q.raw};
                `OFF_MASKED_STATUS:  s_d.rdata = {21'h0, masked};
                default:             s_d.rdata = 32'h0000_0000;
            endcase
        end
        s_d.rtc_run = s_q.ctl[`CTL_RTC_EN];
        s_d.irq     = |(s_d.raw & s_d.mask);
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s_q      <= '0;
            s_q.ctl  <= `CTL_RESET;
            s_q.mask <= `IM_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata   = s_q.rdata;
    assign rtc_run = s_q.rtc_run;
    assign irq     = s_q.irq;

    irq_tracks_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        irq == (|(s_q.raw & s_q.mask))) else $error("irq not matching status");
    rtc_gate_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        rtc_run |-> $past(s_q.ctl[`CTL_RTC_EN])) else $error("rtc ran disabled");
    clear_works_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (wr_en && addr == `OFF_INTERRUPT_CLEAR && wdata[0] && !events[0]) |=> !s_q.raw[0])
        else $error("clear ignored");
    event_sets_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        events[8] |=> s_q.raw[8]) else $error("event lost");
    mask_write_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (wr_en && addr == `OFF_INTERRUPT_MASK) |=> s_q.mask == ($past(wdata[10:0]) & 11'h70F))
        else $error("mask write wrong");
    read_ctl_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (rd_en && addr == `OFF_TIMER_CONTROL && !wr_en) |=> rdata == {17'h0, s_q.ctl})
        else $error("control read wrong");
    trig_first_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (!s_q.ctl[`CTL_FIRST_TRIG])[*2] |-> !first_trigger) else $error("trigger leak");
    run_first_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (!s_q.ctl[`CTL_FIRST_EN])[*2] |-> !first_run) else $error("run while off");
    trig_second_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (!s_q.ctl[`CTL_SECOND_TRIG])[*2] |-> !second_trigger)
        else $error("second trigger leak");
    run_second_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (!s_q.ctl[`CTL_SECOND_EN])[*2] |-> !second_run)
        else $error("second run while off");
    masked_read_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (rd_en && addr == `OFF_MASKED_STATUS) |=>
        rdata == {21'h0, ($past(s_q.raw) & $past(s_q.mask))})
        else $error("masked status read wrong");
    set_wins_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (wr_en && addr == `OFF_INTERRUPT_CLEAR && events[2]) |=> s_q.raw[2])
        else $error("event lost to clear");
endmodule : timer_ctl

// ===== hdl/timer_ctl_defines.svh
// Offsets, field positions and reset values of the timer control block
`ifndef TIMER_CTL_DEFINES_SVH
`define TIMER_CTL_DEFINES_SVH
`define OFF_TIMER_CONTROL   12'h00C
`define OFF_INTERRUPT_MASK  12'h018
`define OFF_RAW_STATUS      12'h01C
`define OFF_MASKED_STATUS   12'h020
`define OFF_INTERRUPT_CLEAR 12'h024
`define OFF_EVENT_INPUTS    12'h050
`define CTL_FIRST_EN        0
`define CTL_FIRST_STALL     1
`define CTL_FIRST_EDGE_LO   2
`define CTL_RTC_EN          4
`define CTL_FIRST_TRIG      5
`define CTL_FIRST_INV       6
`define CTL_SECOND_EN       8
`define CTL_SECOND_STALL    9
`define CTL_SECOND_EDGE_LO  10
`define CTL_SECOND_TRIG     13
`define CTL_SECOND_INV      14
`define CTL_WRITE_MASK      15'h6F7F
`define IM_WRITE_MASK       11'h70F
`define CTL_RESET           15'h0000
`define IM_RESET            11'h000
`endif

// ===== hdl/timer_ctl_pkg.sv
// Types shared by the timer control block
package timer_ctl_pkg;
    typedef enum logic [1:0] {
        EDGE_RISE = 2'h0,
        EDGE_FALL = 2'h1,
        EDGE_RSVD = 2'h2,
        EDGE_BOTH = 2'h3
    } edge_mode_t;

    typedef struct packed {
        logic       enable;
        logic       stall;
        edge_mode_t edge_sel;
        logic       trig_en;
        logic       invert;
    } half_cfg_t;
endpackage : timer_ctl_pkg

// ===== hdl/half_cfg_if.sv
// Per-half configuration carried from the register file to a half's gating
interface half_cfg_if;
    import timer_ctl_pkg::*;
    half_cfg_t cfg;
    logic      halted;
    modport src (output cfg, output halted);
    modport dst (input cfg, input halted);
endinterface : half_cfg_if

// ===== hdl/timer_half_gate.sv
// Gating of one timer half: run, trigger, pwm invert and edge detect
module timer_half_gate
    import timer_ctl_pkg::*;
(
    input  wire logic   clk_sys,
    input  wire logic   resetn,
    half_cfg_if.dst     cfg_in,
    input  wire logic   pwm_raw,
    input  wire logic   trig_raw,
    input  wire logic   cap_in,
    output logic        run,
    output logic        trig_out,
    output logic        pwm_out,
    output logic        cap_event
);
    typedef struct packed {
        logic run;
        logic trig;
        logic pwm;
        logic cap_prev;
        logic cap_evt;
    } state_t;

    state_t s_q;
    state_t s_d;

    function automatic logic edge_hit(input edge_mode_t m, input logic p, input logic c);
        case (m)
            EDGE_RISE: edge_hit = c & ~p;
            EDGE_FALL: edge_hit = ~c & p;
            EDGE_BOTH: edge_hit = c ^ p;
            default:   edge_hit = 1'b0;
        endcase
    endfunction : edge_hit

    always_comb begin
        s_d          = s_q;
        s_d.run      = cfg_in.cfg.enable & ~(cfg_in.cfg.stall & cfg_in.halted);
        s_d.trig     = trig_raw & cfg_in.cfg.trig_en;
        s_d.pwm      = pwm_raw ^ cfg_in.cfg.invert;
        s_d.cap_prev = cap_in;
        s_d.cap_evt  = cfg_in.cfg.enable & edge_hit(cfg_in.cfg.edge_sel, s_q.cap_prev, cap_in);
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign run       = s_q.run;
    assign trig_out  = s_q.trig;
    assign pwm_out   = s_q.pwm;
    assign cap_event = s_q.cap_evt;

    trig_gate_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        !$past(cfg_in.cfg.trig_en) |-> !trig_out) else $error("trigger while disabled");
    pwm_inv_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        $past(resetn) |-> pwm_out == ($past(pwm_raw) ^ $past(cfg_in.cfg.invert)))
        else $error("pwm level wrong");
    stall_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        ($past(cfg_in.cfg.stall) && $past(cfg_in.halted)) |-> !run) else $error("ran in stall");
endmodule : timer_half_gate

// ===== testbench/testbench.sv
// Self-checking bench for the timer control block
`include "timer_ctl_defines.svh"
module testbench import timer_ctl_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_sys = 1'h0;
    logic        resetn = 1'h0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic        wr_en = 1'h0, rd_en = 1'h0, cpu_halted = 1'h0;
    logic [10:0] event_in = 11'h000;
    logic        first_pwm_raw = 1'h0, second_pwm_raw = 1'h0;
    logic        first_trig_raw = 1'h0, second_trig_raw = 1'h0;
    logic        first_cap_in = 1'h0, second_cap_in = 1'h0;
    logic [31:0] rdata;
    logic        first_run, second_run, rtc_run, first_trigger, second_trigger;
    logic        first_pwm_out, second_pwm_out, first_capture_event;
    logic        second_capture_event, irq;
    int          mismatches, compares, cycles, n;
    logic [31:0] d, m, e, c;
    logic [4:0]  s;
    logic [3:0]  cf, cs, ex;
    wire  [6:0]  outs = {first_run, second_run, rtc_run, first_trigger,
                         second_trigger, first_pwm_out, second_pwm_out};

    timer_ctl DUT (.clk_sys, .resetn, .addr, .wdata, .wr_en, .rd_en, .rdata,
        .cpu_halted, .event_in, .first_pwm_raw, .second_pwm_raw, .first_trig_raw,
        .second_trig_raw, .first_cap_in, .second_cap_in, .first_run, .second_run,
        .rtc_run, .first_trigger, .second_trigger, .first_pwm_out, .second_pwm_out,
        .first_capture_event, .second_capture_event, .irq);

    always #5 clk_sys = ~clk_sys;

    // Expected level outputs from control word and side inputs
    function automatic logic [6:0] exp_outs(input logic [31:0] r, input logic [4:0] v);
        return {r[0] & ~(r[1] & v[4]), r[8] & ~(r[9] & v[4]), r[4], v[2] & r[5],
                v[3] & r[13], v[0] ^ r[6], v[1] ^ r[14]};
    endfunction : exp_outs

    task automatic chk_value(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_value

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        addr  <= a;
        wdata <= v;
        wr_en <= 1'h1;
        @(posedge clk_sys);
        wr_en <= 1'h0;
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        addr  <= a;
        rd_en <= 1'h1;
        @(posedge clk_sys);
        rd_en <= 1'h0;
        @(negedge clk_sys);
        chk_value(rdata, exp);
    endtask : rd_chk

    task automatic final_report;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report

    // Hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            final_report();
        end
    end

    initial begin
        void'($urandom(32'h87F1));
        repeat (16) @(posedge clk_sys);
        resetn <= 1'h1;
        rd_chk(`OFF_TIMER_CONTROL, 32'h0);
        rd_chk(`OFF_INTERRUPT_MASK, 32'h0);
        rd_chk(`OFF_MASKED_STATUS, 32'h0);
        chk_value({outs, first_capture_event, second_capture_event, irq}, 32'h0);
        wr(12'h100, $urandom);
        rd_chk(12'h100, 32'h0);
        // Random control words with side inputs
        for (n = 0; n < 40; n++) begin
            d = (n == 0) ? 32'h6F7F : (n == 1) ? 32'h0 : $urandom & 32'h6F7F;
            if (d[11:10] == 2'h2) d[10] = 1'h1;
            if (d[3:2] == 2'h2) d[2] = 1'h1;
            s = $urandom;
            @(posedge clk_sys);
            {cpu_halted, second_trig_raw, first_trig_raw} <= s[4:2];
            {second_pwm_raw, first_pwm_raw} <= s[1:0];
            wr(`OFF_TIMER_CONTROL, d);
            rd_chk(`OFF_TIMER_CONTROL, d);
            chk_value(outs, exp_outs(d, s));
        end
        // Capture edge modes, enabled and disabled
        for (n = 0; n < 8; n++) begin
            if (n % 4 != 2) begin
                d = (32'(n % 4) << 10) | (32'(n / 4) << 8) | (32'(n % 4) << 2) | 32'(n / 4);
                wr(`OFF_TIMER_CONTROL, d);
                repeat (2) begin
                    @(posedge clk_sys);
                    first_cap_in  <= ~first_cap_in;
                    second_cap_in <= ~second_cap_in;
                    ex = (n / 4 == 1 && (n % 4 == 3 || (n % 4 == 0) != first_cap_in)) ? 4'h1 : 4'h0;
                    cf = 4'h0;
                    cs = 4'h0;
                    repeat (4) begin
                        @(negedge clk_sys);
                        cf = cf + first_capture_event;
                        cs = cs + second_capture_event;
                    end
                    chk_value({cf, cs}, {ex, ex});
                end
            end
        end
        // Mask, status and clear
        wr(`OFF_INTERRUPT_CLEAR, 32'h70F);
        for (n = 0; n < 20; n++) begin
            m = (n == 0) ? 32'h70F : (n == 1) ? 32'h0 : $urandom & 32'h70F;
            e = (n < 2) ? 32'h70F : $urandom & 32'h70F;
            c = $urandom & 32'h70F;
            wr(`OFF_INTERRUPT_MASK, m);
            @(posedge clk_sys);
            event_in <= e[10:0];
            @(posedge clk_sys);
            event_in <= 11'h000;
            rd_chk(`OFF_INTERRUPT_MASK, m);
            rd_chk(`OFF_RAW_STATUS, e);
            rd_chk(`OFF_MASKED_STATUS, e & m);
            chk_value(irq, |(e & m));
            wr(`OFF_INTERRUPT_CLEAR, c);
            rd_chk(`OFF_RAW_STATUS, e & ~c);
            rd_chk(`OFF_MASKED_STATUS, e & m & ~c);
            chk_value(irq, |(e & m & ~c));
            wr(`OFF_INTERRUPT_CLEAR, 32'h70F);
        end
        // Event and clear in one cycle: the event stays set
        @(posedge clk_sys);
        addr     <= `OFF_INTERRUPT_CLEAR;
        wdata    <= 32'h70F;
        wr_en    <= 1'h1;
        event_in <= 11'h70F;
        @(posedge clk_sys);
        wr_en    <= 1'h0;
        event_in <= 11'h000;
        rd_chk(`OFF_RAW_STATUS, 32'h70F);
        wr(`OFF_INTERRUPT_CLEAR, 32'h70F);
        rd_chk(`OFF_RAW_STATUS, 32'h0);
        // Reset in mid-run
        wr(`OFF_TIMER_CONTROL, 32'h6F7F);
        wr(`OFF_INTERRUPT_MASK, 32'h70F);
        @(posedge clk_sys);
        resetn <= 1'h0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'h1;
        rd_chk(`OFF_TIMER_CONTROL, 32'h0);
        rd_chk(`OFF_INTERRUPT_MASK, 32'h0);
        final_report();
    end
endmodule : testbench
